// ---- hdl/mixer_auto_top.sv ----
// automation command interpreter for the keyer and mixer card
//
// Behaviour
// - medium and fast rates 1 to 999 frames
// - slow default 60 frames, 50 at 50Hz
// - medium default 30 frames, 25 at 50Hz
// - fast default 15 frames, 12 at 50Hz
// - link runs 38400 baud, 8N1
// - start trigger bits 1 to 7 ignored
// - wipe or custom type answers error
// - local rates; never report type 04; cap 999
// - transition status answers 03 then 01
// - crosspoint bus bits 2 and up ignored
// - crosspoint values 1 to 16 select
// - crosspoint take refused during transition
// - stop, preroll, time, breakaway, audio unsupported
// - key modifier bit0 self/external; others refused/ignored
// - key enable and modifier refuse keyer bit 4
// - automation status query answers enabled
// - port disabled means no answer at all
// - system status answers 0
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mixer_auto_regs.svh"
module mixer_auto_top #(
  parameter int BIT_CLKS = `BIT_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // automation link
  input wire logic UART_RXD,
  output logic UART_TXD,
  // video timing and mixer control
  input wire logic FRAME_PULSE,
  output logic TRANS_BUSY,
  output logic [7:0] PGM_XPT,
  output logic [7:0] PST_XPT,
  output logic [3:0] KEY_ON,
  output logic KEY_EXT
);
  // ==========================================================
  // helpers
  function automatic logic [9:0] clamp_rate(input logic [31:0] v);
    if (v == 32'h0) clamp_rate = 10'h001;
    else if (v > 32'(`RATE_MAX)) clamp_rate = `RATE_MAX;
    else clamp_rate = v[9:0];
  endfunction
  function automatic logic [9:0] eff_rate(input logic [9:0] r, input logic f50,
                                          input logic [9:0] d60, input logic [9:0] d50);
    if (r != 10'h000) eff_rate = r;
    else eff_rate = f50 ? d50 : d60;
  endfunction
  function automatic logic [1:0] arg_count(input logic [7:0] c);
    if (c[`QUERY_BIT]) arg_count = 2'h0;
    else case (c[6:0])
      `C_NEXT, `C_START, `C_TYPE, `C_RATE, `C_KEN: arg_count = 2'h1;
      `C_XPT, `C_KMOD: arg_count = 2'h2;
      default: arg_count = 2'h0;
    endcase
  endfunction
  // ==========================================================
  // apb registers
  logic port_en_r;
  logic fmt50_r;
  logic [9:0] slow_r;
  logic [9:0] med_r;
  logic [9:0] fast_r;
  logic [9:0] slow_eff;
  logic [9:0] med_eff;
  logic [9:0] fast_eff;
  logic [7:0] last_cmd_r;
  logic last_nak_r;
  logic wr_en;
  logic addr_ok;
  // a zero register means "use the format default", so reset needs no strap
  assign slow_eff = eff_rate(slow_r, fmt50_r, `DEF_SLOW_60, `DEF_SLOW_50);
  assign med_eff = eff_rate(med_r, fmt50_r, `DEF_MED_60, `DEF_MED_50);
  assign fast_eff = eff_rate(fast_r, fmt50_r, `DEF_FAST_60, `DEF_FAST_50);
  assign addr_ok = PADDR inside {`OFS_CTRL, `OFS_SLOW, `OFS_MED, `OFS_FAST,
                                 `OFS_STAT, `OFS_LAST};
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      port_en_r <= `CTRL_RST;
      fmt50_r <= 1'b0;
      slow_r <= 10'h000;
      med_r <= 10'h000;
      fast_r <= 10'h000;
    end else if (wr_en) begin
      case (PADDR)
        `OFS_CTRL: begin
          port_en_r <= PWDATA[`CTRL_PORT_EN];
          fmt50_r <= PWDATA[`CTRL_FMT50];
        end
        `OFS_SLOW: slow_r <= clamp_rate(PWDATA);
        `OFS_MED: med_r <= clamp_rate(PWDATA);
        `OFS_FAST: fast_r <= clamp_rate(PWDATA);
        default: ;
      endcase
    end
  end
  // ==========================================================
  // parser and command execution
  mixer_auto_pkg::parse_e st_r;
  logic [7:0] rx_data;
  logic rx_valid;
  logic tx_ready;
  logic tx_go_r;
  logic [7:0] tx_data_r;
  logic [7:0] cmd_r;
  logic [7:0] a0_r;
  logic [7:0] a1_r;
  logic [1:0] argn_r;
  logic [7:0] rep0_r;
  logic [7:0] rep1_r;
  logic [1:0] repn_r;
  logic [3:0] next_r;
  logic [7:0] ttype_r;
  logic [1:0] rate_sel_r;
  logic start_go_r;
  logic start_cut_r;
  logic xpt_go_r;
  logic busy_r;
  logic q;
  logic [6:0] c;
  assign q = cmd_r[`QUERY_BIT];
  assign c = cmd_r[6:0];
  if (BIT_CLKS < 4 || BIT_CLKS > 65535) begin : g_bad_bit
    $error("mixer_auto_top: BIT_CLKS out of range");
  end
  link_rx #(.CLKS(BIT_CLKS)) u_rx (
    .clk(CLK),
    .rst(RST),
    .rxd(UART_RXD),
    .data(rx_data),
    .valid(rx_valid)
  );
  link_tx #(.CLKS(BIT_CLKS)) u_tx (
    .clk(CLK),
    .rst(RST),
    .go(tx_go_r),
    .data(tx_data_r),
    .ready(tx_ready),
    .txd(UART_TXD)
  );
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= mixer_auto_pkg::ST_CMD;
      cmd_r <= 8'h00;
      a0_r <= 8'h00;
      a1_r <= 8'h00;
      argn_r <= 2'h0;
      rep0_r <= 8'h00;
      rep1_r <= 8'h00;
      repn_r <= 2'h0;
      tx_go_r <= 1'b0;
      tx_data_r <= 8'h00;
      next_r <= 4'h0;
      ttype_r <= 8'h01;
      rate_sel_r <= 2'h3;
      start_go_r <= 1'b0;
      start_cut_r <= 1'b0;
      xpt_go_r <= 1'b0;
      KEY_ON <= 4'h0;
      KEY_EXT <= 1'b0;
      last_cmd_r <= 8'h00;
      last_nak_r <= 1'b0;
    end else begin
      tx_go_r <= 1'b0;
      start_go_r <= 1'b0;
      xpt_go_r <= 1'b0;
      case (st_r)
        mixer_auto_pkg::ST_CMD: if (rx_valid) begin
          cmd_r <= rx_data;
          argn_r <= arg_count(rx_data);
          st_r <= (arg_count(rx_data) == 2'h0) ? mixer_auto_pkg::ST_EXEC
                                               : mixer_auto_pkg::ST_ARG;
        end
        mixer_auto_pkg::ST_ARG: if (rx_valid) begin
          a0_r <= rx_data;
          a1_r <= a0_r;
          argn_r <= argn_r - 2'h1;
          if (argn_r == 2'h1) st_r <= mixer_auto_pkg::ST_EXEC;
        end
        mixer_auto_pkg::ST_EXEC: begin
          // with two arguments a1 holds the first byte and a0 the second
          last_cmd_r <= cmd_r;
          rep0_r <= `R_ACK;
          repn_r <= 2'h1;
          last_nak_r <= 1'b0;
          st_r <= port_en_r ? mixer_auto_pkg::ST_SEND : mixer_auto_pkg::ST_CMD;
          case (c)
            `C_NEXT: if (q) rep0_r <= {3'h0, next_r, 1'b0};
              else next_r <= a0_r[4:1];
            `C_START: if (q || busy_r) begin
              rep0_r <= `R_NAK;
              last_nak_r <= 1'b1;
            end else if (port_en_r) begin
              start_go_r <= 1'b1;
              start_cut_r <= a0_r[0];
            end
            `C_TYPE: if (q) rep0_r <= ttype_r;
              else if (a0_r == `T_WIPE || a0_r > `T_MAXOK) begin
                rep0_r <= `R_NAK;
                last_nak_r <= 1'b1;
              end else if (port_en_r) ttype_r <= a0_r;
            `C_RATE: if (q) rep0_r <= {6'h00, rate_sel_r};
              else if (a0_r == 8'h00 || a0_r > 8'h03) begin
                rep0_r <= `R_NAK;
                last_nak_r <= 1'b1;
              end else if (port_en_r) rate_sel_r <= a0_r[1:0];
            `C_TSTAT, `C_TSTAT2: begin
              rep0_r <= `R_INPROG;
              rep1_r <= `R_AUDIO_Q;
              repn_r <= 2'h2;
            end
            `C_XPT: if (q || busy_r || a0_r > `XPT_MAX) begin
              rep0_r <= `R_NAK;
              last_nak_r <= 1'b1;
            end else xpt_go_r <= port_en_r;
            `C_KMOD: if (q || a1_r[4] || a0_r[1]) begin
              rep0_r <= `R_NAK;
              last_nak_r <= 1'b1;
            end else if (port_en_r) KEY_EXT <= a0_r[0];
            `C_KEN: if (q) rep0_r <= {4'h0, KEY_ON};
              else if (a0_r[4]) begin
                rep0_r <= `R_NAK;
                last_nak_r <= 1'b1;
              end else if (port_en_r) KEY_ON <= a0_r[3:0];
            `C_KSTAT: rep0_r <= {4'h0, KEY_ON};
            `C_AUTO: if (q) rep0_r <= `R_ENABLED;
            `C_SYS: rep0_r <= `R_SYS_OK;
            7'h07, 7'h08, 7'h09, 7'h0e, 7'h0f, 7'h10, 7'h11: begin
              rep0_r <= `R_NAK;
              last_nak_r <= 1'b1;
            end
            default: begin
              rep0_r <= `R_NAK;
              last_nak_r <= 1'b1;
            end
          endcase
        end
        mixer_auto_pkg::ST_SEND: if (tx_ready && !tx_go_r) begin
          tx_go_r <= 1'b1;
          tx_data_r <= rep0_r;
          rep0_r <= rep1_r;
          repn_r <= repn_r - 2'h1;
          if (repn_r == 2'h1) st_r <= mixer_auto_pkg::ST_CMD;
        end
        default: st_r <= mixer_auto_pkg::ST_CMD;
      endcase
    end
  end
  // ==========================================================
  // transition timing and crosspoints
  logic [9:0] cnt_r;
  logic [9:0] tgt_r;
  logic [9:0] cnt_inc;
  assign cnt_inc = cnt_r + 10'h001;
  assign TRANS_BUSY = busy_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_r <= 1'b0;
      cnt_r <= 10'h000;
      tgt_r <= 10'h001;
      PGM_XPT <= 8'h00;
      PST_XPT <= 8'h00;
    end else begin
      if (start_go_r) begin
        if (start_cut_r) begin
          PGM_XPT <= PST_XPT;
          PST_XPT <= PGM_XPT;
        end else begin
          busy_r <= 1'b1;
          cnt_r <= 10'h000;
          case (rate_sel_r)
            2'h1: tgt_r <= slow_eff;
            2'h2: tgt_r <= med_eff;
            default: tgt_r <= fast_eff;
          endcase
        end
      end else if (busy_r && FRAME_PULSE) begin
        cnt_r <= cnt_inc;
        if (cnt_inc >= tgt_r) begin
          busy_r <= 1'b0;
          PGM_XPT <= PST_XPT;
          PST_XPT <= PGM_XPT;
        end
      end else if (xpt_go_r && a0_r != 8'h00) begin
        // only the two low bus bits mean anything
        if (a1_r[0]) PGM_XPT <= a0_r;
        if (a1_r[1]) PST_XPT <= a0_r;
      end
    end
  end
  // ==========================================================
  // read data, registered in the setup cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) PRDATA <= 32'h00000000;
    else if (PSEL && !PENABLE) begin
      case (PADDR)
        `OFS_CTRL: PRDATA <= {30'h0, fmt50_r, port_en_r};
        `OFS_SLOW: PRDATA <= {22'h0, slow_eff};
        `OFS_MED: PRDATA <= {22'h0, med_eff};
        `OFS_FAST: PRDATA <= {22'h0, fast_eff};
        `OFS_STAT: PRDATA <= {8'h00, PST_XPT, PGM_XPT, rate_sel_r, KEY_EXT, KEY_ON, busy_r};
        `OFS_LAST: PRDATA <= {23'h0, last_nak_r, last_cmd_r};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic exec;
  assign exec = st_r == mixer_auto_pkg::ST_EXEC;
  AST_RATE_RANGE: assert property (med_eff inside {[10'd1:10'd999]} &&
      fast_eff inside {[10'd1:10'd999]}) else $error("rate out of range");
  AST_SLOW_DEF: assert property (slow_r == 10'h0 |-> slow_eff ==
      (fmt50_r ? 10'd50 : 10'd60)) else $error("slow default wrong");
  AST_MED_DEF: assert property ($fell(RST) |-> med_eff == 10'd30)
    else $error("medium default wrong");
  AST_FAST_DEF: assert property (fast_r == 10'h0 && fmt50_r |-> fast_eff == 10'd12)
    else $error("fast default wrong");
  AST_RATE_REPLY: assert property (exec && q && c == `C_RATE |=>
      rep0_r inside {8'h01, 8'h02, 8'h03}) else $error("bad rate reply");
  AST_TSTAT: assert property (exec && (c == `C_TSTAT || c == `C_TSTAT2) |=>
      rep0_r == 8'h03 && rep1_r == 8'h01 && repn_r == 2'h2) else $error("bad status");
  AST_HOT_CUT: assert property (exec && c == `C_XPT && busy_r |=>
      rep0_r == `R_NAK && !xpt_go_r) else $error("take during transition");
  AST_WIPE: assert property (exec && !q && c == `C_TYPE && a0_r == 8'h02 |=>
      rep0_r == `R_NAK && $stable(ttype_r)) else $error("wipe accepted");
  AST_MUTE: assert property (exec && !port_en_r |=>
      st_r == mixer_auto_pkg::ST_CMD ##1 !tx_go_r) else $error("reply while disabled");
  AST_SYS: assert property (exec && q && c == `C_SYS |=> rep0_r == 8'h00)
    else $error("system status not ok");
  AST_DONE: assert property ($fell(busy_r) |-> $past(FRAME_PULSE) &&
      $past(cnt_r) + 10'd1 == $past(tgt_r)) else $error("early completion");
endmodule // mixer_auto_top

// ---- hdl/mixer_auto_regs.svh ----
// register map, field positions, defaults and codes of the automation interpreter
`ifndef MIXER_AUTO_REGS_SVH
`define MIXER_AUTO_REGS_SVH
// ==========================================================
// timing
`define CLK_HZ 50000000
`define LINK_BAUD 38400
`define BIT_CYCLES (`CLK_HZ / `LINK_BAUD)
// ==========================================================
// register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_SLOW 8'h04
`define OFS_MED 8'h08
`define OFS_FAST 8'h0c
`define OFS_STAT 8'h10
`define OFS_LAST 8'h14
// ==========================================================
// fields
`define CTRL_PORT_EN 0
`define CTRL_FMT50 1
`define CTRL_RST 1'h1
`define RATE_MAX 10'h3e7
`define DEF_SLOW_60 10'h03c
`define DEF_SLOW_50 10'h032
`define DEF_MED_60 10'h01e
`define DEF_MED_50 10'h019
`define DEF_FAST_60 10'h00f
`define DEF_FAST_50 10'h00c
// ==========================================================
// command codes, query flag and answers
`define QUERY_BIT 7
`define C_NEXT 7'h01
`define C_START 7'h02
`define C_TYPE 7'h03
`define C_RATE 7'h04
`define C_TSTAT 7'h05
`define C_XPT 7'h06
`define C_KMOD 7'h0a
`define C_KEN 7'h0b
`define C_KSTAT 7'h0c
`define C_AUTO 7'h0d
`define C_SYS 7'h12
`define C_TSTAT2 7'h15
`define T_WIPE 8'h02
`define T_MAXOK 8'h01
`define XPT_MAX 8'h10
`define R_ACK 8'h04
`define R_NAK 8'h05
`define R_INPROG 8'h03
`define R_AUDIO_Q 8'h01
`define R_ENABLED 8'h01
`define R_SYS_OK 8'h00
`endif

// ---- hdl/mixer_auto_pkg.sv ----
// types shared by the automation interpreter
package mixer_auto_pkg;
  typedef enum logic [3:0] {
    ST_CMD = 4'b0001,
    ST_ARG = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_SEND = 4'b1000
  } parse_e;
endpackage

// ---- hdl/link_rx.sv ----
// serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module link_rx #(
  parameter int CLKS = 1302
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // line and received byte
  input wire logic rxd,
  output logic [7:0] data,
  output logic valid
);
  localparam logic [15:0] FULL = 16'(CLKS - 1);
  localparam logic [15:0] HALF = 16'(CLKS / 2);
  logic busy_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  if (CLKS < 4 || CLKS > 65535) begin : g_bad_clks
    $error("link_rx: CLKS out of range");
  end
  // ==========================================================
  // sampling at mid bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      data <= 8'h00;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!busy_r) begin
        if (!rxd) begin
          busy_r <= 1'b1;
          cnt_r <= HALF;
          bit_r <= 4'h0;
        end
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        cnt_r <= FULL;
        bit_r <= bit_r + 4'h1;
        // a glitch shorter than half a bit is not a start
        if (bit_r == 4'h0 && rxd) busy_r <= 1'b0;
        else if (bit_r != 4'h0 && bit_r < 4'h9) sh_r <= {rxd, sh_r[7:1]};
        else if (bit_r == 4'h9) begin
          busy_r <= 1'b0;
          valid <= rxd;
          data <= sh_r;
        end
      end
    end
  end
endmodule // link_rx

// ---- hdl/link_tx.sv ----
// serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module link_tx #(
  parameter int CLKS = 1302
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte in
  input wire logic go,
  input wire logic [7:0] data,
  output logic ready,
  // line
  output logic txd
);
  localparam logic [15:0] FULL = 16'(CLKS - 1);
  logic busy_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_r;
  logic [9:0] sh_r;
  if (CLKS < 4 || CLKS > 65535) begin : g_bad_clks
    $error("link_tx: CLKS out of range");
  end
  assign ready = !busy_r;
  // ==========================================================
  // shifter, lsb first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 10'h3ff;
      txd <= 1'b1;
    end else if (!busy_r) begin
      txd <= 1'b1;
      if (go) begin
        busy_r <= 1'b1;
        sh_r <= {1'b1, data, 1'b0};
        cnt_r <= FULL;
        bit_r <= 4'h0;
        txd <= 1'b0;
      end
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end else begin
      cnt_r <= FULL;
      bit_r <= bit_r + 4'h1;
      sh_r <= {1'b1, sh_r[9:1]};
      txd <= sh_r[1];
      if (bit_r == 4'h9) begin
        busy_r <= 1'b0;
        txd <= 1'b1;
      end
    end
  end
endmodule // link_tx

// ---- bench/auto_ctrl_model.sv ----
// automation controller model: sends command bytes, decodes reply bytes
`timescale 1ns/1ps
module auto_ctrl_model #(
  parameter int BIT = 1302
) (
  // clock
  input wire logic clk,
  // serial lines
  output logic rxd_out,
  input wire logic txd_in,
  // decoded reply
  output logic got,
  output logic [7:0] got_byte
);
  // ==========================================================
  // sender
  // idle line rests high between frames, as the receiver expects
  initial rxd_out = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // ==========================================================
  // receiver, samples mid-bit
  initial begin
    logic [7:0] b;
    got = 1'b0;
    got_byte = 8'h00;
    forever begin
      @(negedge txd_in);
      repeat (BIT / 2) @(posedge clk);
      if (txd_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge clk);
          b[i] = txd_in;
        end
        repeat (BIT) @(posedge clk);
        // a bad stop bit drops the byte, so the pending check catches it
        if (txd_in === 1'b1) begin
          got_byte <= b;
          got <= 1'b1;
          @(posedge clk);
          got <= 1'b0;
        end
      end
    end
  end
endmodule // auto_ctrl_model

// ---- bench/switcher_automation_cmd_interpreter_tb.sv ----
// self-checking bench of the automation command interpreter
`timescale 1ns/1ps
`include "mixer_auto_regs.svh"
module switcher_automation_cmd_interpreter_tb;
  // ==========================================================
  // signals
  logic CLK = 1'b0;
  // short bit time keeps the run brief; the card's own divisor is checked apart
  localparam int BITC = 16;
  logic RST;
  logic PSEL;
  logic PENABLE;
  logic PWRITE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic UART_RXD;
  logic UART_TXD;
  logic FRAME_PULSE;
  logic TRANS_BUSY;
  logic [7:0] PGM_XPT;
  logic [7:0] PST_XPT;
  logic [3:0] KEY_ON;
  logic KEY_EXT;
  logic got;
  logic [7:0] got_byte;
  logic [32:0] apb_q[$];
  logic [7:0] link_q[$];
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] v;
  logic [31:0] e;
  always #10 CLK = ~CLK;
  // ==========================================================
  // design and far side
  mixer_auto_top #(.BIT_CLKS(BITC)) DUT (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .UART_RXD(UART_RXD), .UART_TXD(UART_TXD),
    .FRAME_PULSE(FRAME_PULSE), .TRANS_BUSY(TRANS_BUSY), .PGM_XPT(PGM_XPT),
    .PST_XPT(PST_XPT), .KEY_ON(KEY_ON), .KEY_EXT(KEY_EXT)
  );
  auto_ctrl_model #(.BIT(BITC)) ctl (
    .clk(CLK), .rxd_out(UART_RXD), .txd_in(UART_TXD), .got(got), .got_byte(got_byte)
  );
  // ==========================================================
  // compare and finish
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic err, input logic [31:0] x);
    apb_q.push_back({err, x});
    apb(1'b0, a, 32'h0);
  endtask
  // waits for every noted reply byte, bounded
  task automatic settle(input int lim);
    int c;
    c = 0;
    while (link_q.size() != 0 && c < lim) begin
      @(posedge CLK);
      c++;
    end
    chk("pending replies", 33'(link_q.size()), 33'h0);
  endtask
  // one command of n bytes; its m reply bytes are noted before it goes out
  task automatic cmd(input int n, input logic [23:0] b, input logic [15:0] r, input int m);
    for (int i = 0; i < m; i++) link_q.push_back(r[8 * (m - 1 - i) +: 8]);
    for (int i = 0; i < n; i++) ctl.send(b[8 * (n - 1 - i) +: 8]);
    settle(40 * BITC);
  endtask
  // status word read back, then the ports looked at off the edge
  task automatic st(input logic [23:0] x);
    rd(`OFS_STAT, 1'b0, {8'h00, x});
    @(negedge CLK);
    chk("outputs", {11'h0, PST_XPT, PGM_XPT, KEY_EXT, KEY_ON, TRANS_BUSY},
        {11'h0, x[23:8], x[5:0]});
    @(posedge CLK);
  endtask
  task automatic pulse();
    FRAME_PULSE <= 1'b1;
    @(posedge CLK);
    FRAME_PULSE <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask
  // ==========================================================
  // monitors
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      if (apb_q.size() == 0) chk("unexpected read", 33'h1, 33'h0);
      else chk("apb read", {PSLVERR, PRDATA}, apb_q.pop_front());
    end
    if (got) begin
      if (link_q.size() == 0) chk("unexpected reply", {25'h0, got_byte}, 33'h1ff);
      else chk("reply byte", {25'h0, got_byte}, {25'h0, link_q.pop_front()});
    end
  end
  // ==========================================================
  // tests
  initial begin
    RST <= 1'b1;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWRITE <= 1'b0;
    PADDR <= 8'h00;
    PWDATA <= 32'h0;
    FRAME_PULSE <= 1'b0;
    void'($urandom(66));
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    // defaults at 59.94 and idle status, fast rate selected
    rd(`OFS_SLOW, 1'b0, 32'h3c);
    rd(`OFS_MED, 1'b0, 32'h1e);
    rd(`OFS_FAST, 1'b0, 32'h0f);
    rd(`OFS_STAT, 1'b0, 32'hc0);
    rd(8'h20, 1'b1, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h3);
    rd(`OFS_CTRL, 1'b0, 32'h3);
    rd(`OFS_SLOW, 1'b0, 32'h32);
    rd(`OFS_MED, 1'b0, 32'h19);
    rd(`OFS_FAST, 1'b0, 32'h0c);
    $display("test defaults done");
    // rate limits: both ends and random values, clamped to 1..999
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'h3ff : (i == 2) ? 32'h3e7 : {22'h0, 10'($urandom)};
      e = (v == 0) ? 32'h1 : (v > 999) ? 32'h3e7 : v;
      apb(1'b1, i[0] ? `OFS_FAST : `OFS_MED, v);
      rd(i[0] ? `OFS_FAST : `OFS_MED, 1'b0, e);
    end
    $display("test rates done");
    // system status query
    link_q.push_back(8'h00);
    ctl.send(8'h92);
    settle(20000);
    // transition status query
    link_q.push_back(8'h03);
    link_q.push_back(8'h01);
    ctl.send(8'h95);
    settle(35000);
    $display("test link queries done");
    chk("bit period", 33'(`BIT_CYCLES), 33'(50000000 / 38400));
    // takes, a cut and a timed transition, read back and seen on the ports
    e = 32'(1 + $urandom % 16);
    cmd(3, 24'h060105, 16'h04, 1);
    cmd(3, {16'h06fe, e[7:0]}, 16'h04, 1);
    cmd(3, 24'h060111, 16'h05, 1);
    st({e[7:0], 16'h05c0});
    cmd(2, 24'h02fb, 16'h04, 1);
    st({8'h05, e[7:0], 8'hc0});
    v = 32'(1 + $urandom % 6);
    apb(1'b1, `OFS_FAST, v);
    cmd(2, 24'h02fe, 16'h04, 1);
    cmd(3, 24'h060102, 16'h05, 1);
    cmd(2, 24'h0200, 16'h05, 1);
    repeat (v - 1) pulse();
    st({8'h05, e[7:0], 8'hc1});
    pulse();
    st({e[7:0], 8'h05, 8'hc0});
    $display("test take and transition done");
    // keys, type, rate, next selection and unsupported codes
    cmd(2, 24'h0b05, 16'h04, 1);
    cmd(2, 24'h0b15, 16'h05, 1);
    cmd(1, 24'h8c, 16'h05, 1);
    cmd(3, 24'h0a011d, 16'h04, 1);
    cmd(3, 24'h0a0102, 16'h05, 1);
    cmd(3, 24'h0a1000, 16'h05, 1);
    st({e[7:0], 8'h05, 8'hea});
    cmd(2, 24'h0302, 16'h05, 1);
    cmd(2, 24'h0300, 16'h04, 1);
    cmd(1, 24'h83, 16'h00, 1);
    cmd(2, 24'h0404, 16'h05, 1);
    cmd(2, 24'h0401, 16'h04, 1);
    cmd(1, 24'h84, 16'h01, 1);
    cmd(2, 24'h0403, 16'h04, 1);
    cmd(2, 24'h0103, 16'h04, 1);
    cmd(1, 24'h81, 16'h02, 1);
    cmd(1, 24'h8d, 16'h01, 1);
    cmd(1, 24'h85, 16'h0301, 2);
    v = 32'($urandom % 7);
    e = (v < 3) ? v + 32'h7 : v + 32'hb;
    cmd(1, {16'h0000, e[7:0]}, 16'h05, 1);
    rd(`OFS_LAST, 1'b0, {23'h0, 1'b1, e[7:0]});
    $display("test command set done");
    // port disabled: automation status query gets no answer at all
    apb(1'b1, `OFS_CTRL, 32'h2);
    ctl.send(8'h8d);
    repeat (40 * BITC) @(posedge CLK);
    chk("silent line", {32'h0, UART_TXD}, 33'h1);
    $display("test port disabled done");
    wrap_up();
  end
  initial begin
    repeat (50000) @(posedge CLK);
    fail_count++;
    wrap_up();
  end
endmodule // switcher_automation_cmd_interpreter_tb
